//--- flash_host_cfg.svh
// constants for the flash ready/busy and power-state host controller
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH
// ****************************************************************
// register map
// ****************************************************************
`define CTRL_OFS 8'h00
`define CMD_OFS 8'h04
`define DATA_OFS 8'h08
`define ADDR_OFS 8'h0C
`define STAT_OFS 8'h10
`define RDATA_OFS 8'h14
`define CTRL_AUTO_BIT 8
`define STAT_SEQ_BUSY_BIT 0
`define STAT_FLASH_BUSY_BIT 1
`define STAT_PD_BIT 2
`define STAT_ARRAY_BIT 3
`define STAT_BYTE_LSB 16
// ****************************************************************
// operation codes and commands
// ****************************************************************
`define OP_WR1 3'h1
`define OP_WR2 3'h2
`define OP_RD 3'h3
`define OP_PD_ON 3'h4
`define OP_PD_OFF 3'h5
`define RD_ARRAY_CMD 8'hFF
// ****************************************************************
// timing
// ****************************************************************
`define CLK_MHZ 50
`define WE_LOW_NS 60
`define RD_ACC_NS 100
`define PD_READ_NS 600
`define PD_WRITE_NS 1000
`define SYNC_CYC 2
`define WE_CYC (((`WE_LOW_NS * `CLK_MHZ) + 999) / 1000)
`define RD_CYC ((((`RD_ACC_NS * `CLK_MHZ) + 999) / 1000) + `SYNC_CYC)
`define PD_READ_CYC (((`PD_READ_NS * `CLK_MHZ) + 999) / 1000)
`define PD_WRITE_CYC (((`PD_WRITE_NS * `CLK_MHZ) + 999) / 1000)
`define WAKE_CYC ((`PD_WRITE_CYC > `PD_READ_CYC) ? `PD_WRITE_CYC : `PD_READ_CYC)
`endif

//--- flash_host_pkg.sv
// types shared by the flash host controller
`default_nettype none
package flash_host_pkg;
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_SETUP = 3'b001,
        S_WE = 3'b010,
        S_HOLD = 3'b011,
        S_POLL = 3'b100,
        S_RD = 3'b101,
        S_WAKE = 3'b110
    } seq_state_t;
    typedef struct packed {
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic rp_n;
        logic dq_oe_n;
    } pin_ctl_t;
endpackage
`default_nettype wire

//--- flash_host.sv
// apb-controlled host sequencer for a parallel flash with ready/busy
//
// The implementer's own choices: register access over APB and the register addresses.
`include "flash_host_cfg.svh"
`default_nettype none
module flash_host #(
    parameter int ADDR_W = 18
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output flash_host_pkg::pin_ctl_t pins_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic [15:0] dq_o,
    input wire logic [15:0] dq_i,
    input wire logic ready_busy_n_i
);
    // ****************************************************************
    // parameter check
    // ****************************************************************
    if (ADDR_W < 1 || ADDR_W > 32) begin : g_bad_width
        $error("ADDR_W must be 1 to 32");
    end

    localparam logic [7:0] WE_C = 8'(`WE_CYC);
    localparam logic [7:0] RD_C = 8'(`RD_CYC);
    localparam logic [7:0] WAKE_C = 8'(`WAKE_CYC);
    localparam logic [7:0] SYNC_C = 8'(`SYNC_CYC);

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [16:0] meta_q;
    logic [16:0] sync_q;
    // two flops for data bus and ready_busy_n
    always_ff @(posedge ref_clk_i) begin
        meta_q <= {ready_busy_n_i, dq_i};
        sync_q <= meta_q;
    end
    logic rb_ready;
    logic [15:0] dq_sync;
    assign rb_ready = sync_q[16];
    assign dq_sync = sync_q[15:0];

    // ****************************************************************
    // sequencer and register state
    // ****************************************************************
    flash_host_pkg::seq_state_t state_q, state_d;
    flash_host_pkg::pin_ctl_t pins_q, pins_d;
    logic [7:0] cnt_q, cnt_d;
    logic [2:0] op_q, op_d;
    logic [1:0] phase_q, phase_d;
    logic [7:0] cmd_q, cmd_d;
    logic [15:0] data_q, data_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic auto_q, auto_d;
    logic pd_q, pd_d;
    logic array_q, array_d;
    logic [7:0] status_q, status_d;
    logic [15:0] rdata_q, rdata_d;
    logic [15:0] dq_q, dq_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic setup_ph;
    logic access_wr;
    logic start;
    logic [2:0] new_op;
    logic bad;
    logic [7:0] out_byte;

    assign setup_ph = psel_i && !penable_i;
    assign access_wr = psel_i && penable_i && pready_q && pwrite_i && !pslverr_q;
    assign start = access_wr && (paddr_i == `CTRL_OFS);
    assign new_op = pwdata_i[2:0];

    // next values of bus answer, registers and sequencer
    always_comb begin
        state_d = state_q;
        pins_d = pins_q;
        cnt_d = cnt_q;
        op_d = op_q;
        phase_d = phase_q;
        cmd_d = cmd_q;
        data_d = data_q;
        addr_d = addr_q;
        auto_d = auto_q;
        pd_d = pd_q;
        array_d = array_q;
        status_d = status_q;
        rdata_d = rdata_q;
        dq_d = dq_q;
        prdata_d = prdata_q;
        pready_d = 1'b1;
        pslverr_d = pslverr_q;
        bad = 1'b0;
        out_byte = (phase_q == 2'd0) ? cmd_q : `RD_ARRAY_CMD;
        // answer prepared in the setup cycle, shown in the access cycle
        if (setup_ph) begin
            prdata_d = 32'h0000_0000;
            case (paddr_i)
                `CTRL_OFS: begin
                    prdata_d[`CTRL_AUTO_BIT] = auto_q;
                    prdata_d[2:0] = op_q;
                    // no pin activity while powered down
                    bad = pwrite_i && (state_q != flash_host_pkg::S_IDLE
                        || (pd_q && new_op != `OP_PD_OFF)
                        || (!pd_q && new_op == `OP_PD_OFF)
                        || new_op == 3'h0 || new_op > `OP_PD_OFF);
                end
                `CMD_OFS: prdata_d[7:0] = cmd_q;
                `DATA_OFS: prdata_d[15:0] = data_q;
                `ADDR_OFS: prdata_d[ADDR_W-1:0] = addr_q;
                `STAT_OFS: begin
                    prdata_d[`STAT_SEQ_BUSY_BIT] = state_q != flash_host_pkg::S_IDLE;
                    prdata_d[`STAT_FLASH_BUSY_BIT] = !rb_ready;
                    prdata_d[`STAT_PD_BIT] = pd_q;
                    prdata_d[`STAT_ARRAY_BIT] = array_q;
                    prdata_d[`STAT_BYTE_LSB +: 8] = status_q;
                    bad = pwrite_i;
                end
                `RDATA_OFS: begin
                    prdata_d[15:0] = rdata_q;
                    bad = pwrite_i;
                end
                default: bad = 1'b1;
            endcase
            pslverr_d = bad;
            if (bad) begin
                prdata_d = 32'h0000_0000;
            end
        end
        // register writes take effect at the access edge
        if (access_wr) begin
            case (paddr_i)
                `CTRL_OFS: auto_d = pwdata_i[`CTRL_AUTO_BIT];
                `CMD_OFS: cmd_d = pwdata_i[7:0];
                `DATA_OFS: data_d = pwdata_i[15:0];
                `ADDR_OFS: addr_d = pwdata_i[ADDR_W-1:0];
                default: ;
            endcase
        end
        case (state_q)
            flash_host_pkg::S_IDLE: begin
                if (start) begin
                    op_d = new_op;
                    phase_d = 2'd0;
                    case (new_op)
                        // every start replays the whole sequence
                        `OP_WR1, `OP_WR2: state_d = flash_host_pkg::S_SETUP;
                        `OP_RD: begin
                            state_d = flash_host_pkg::S_RD;
                            pins_d.ce_n = 1'b0;
                            pins_d.oe_n = 1'b0;
                            cnt_d = RD_C;
                        end
                        `OP_PD_ON: begin
                            // device clears its status, so does our copy
                            pins_d.rp_n = 1'b0;
                            pd_d = 1'b1;
                            status_d = 8'h00;
                        end
                        `OP_PD_OFF: begin
                            pins_d.rp_n = 1'b1;
                            pd_d = 1'b0;
                            array_d = 1'b1;
                            state_d = flash_host_pkg::S_WAKE;
                            cnt_d = WAKE_C;
                        end
                        default: ;
                    endcase
                end
            end
            flash_host_pkg::S_SETUP: begin
                // chip enable and data set up before write enable
                pins_d.ce_n = 1'b0;
                pins_d.dq_oe_n = 1'b0;
                dq_d = (phase_q == 2'd1) ? data_q : {8'h00, out_byte};
                if (phase_q != 2'd1) begin
                    // only byte FFH selects read-array mode
                    array_d = out_byte == `RD_ARRAY_CMD;
                end
                state_d = flash_host_pkg::S_WE;
                cnt_d = WE_C;
            end
            flash_host_pkg::S_WE: begin
                // write enable low only under chip enable
                pins_d.we_n = 1'b0;
                cnt_d = cnt_q - 8'h01;
                // strobe stays low for the full WE_C cycles
                if (cnt_q == 8'h00) begin
                    pins_d.we_n = 1'b1;
                    state_d = flash_host_pkg::S_HOLD;
                end
            end
            flash_host_pkg::S_HOLD: begin
                pins_d.ce_n = 1'b1;
                pins_d.dq_oe_n = 1'b1;
                state_d = flash_host_pkg::S_IDLE;
                if (op_q == `OP_WR2 && phase_q == 2'd0) begin
                    // second write of the two-step sequence
                    phase_d = 2'd1;
                    state_d = flash_host_pkg::S_SETUP;
                end else if (op_q == `OP_WR2 && phase_q == 2'd1) begin
                    // busy must pass the synchroniser before we look or go idle
                    cnt_d = SYNC_C;
                    state_d = flash_host_pkg::S_POLL;
                end
            end
            flash_host_pkg::S_POLL: begin
                if (cnt_q != 8'h00) begin
                    cnt_d = cnt_q - 8'h01;
                end
                // without auto, idle only once busy is visible in status
                if (!auto_q && cnt_q == 8'h01) begin
                    state_d = flash_host_pkg::S_IDLE;
                end
                // read-array issued once the device is ready
                if (auto_q && cnt_q == 8'h00 && rb_ready) begin
                    phase_d = 2'd2;
                    state_d = flash_host_pkg::S_SETUP;
                end
            end
            flash_host_pkg::S_RD: begin
                cnt_d = cnt_q - 8'h01;
                if (cnt_q == 8'h01) begin
                    rdata_d = dq_sync;
                    if (!array_q) begin
                        status_d = dq_sync[7:0];
                    end
                    pins_d.ce_n = 1'b1;
                    pins_d.oe_n = 1'b1;
                    state_d = flash_host_pkg::S_IDLE;
                end
            end
            flash_host_pkg::S_WAKE: begin
                // hold off accesses for the exit delays
                cnt_d = cnt_q - 8'h01;
                if (cnt_q == 8'h01) begin
                    state_d = flash_host_pkg::S_IDLE;
                end
            end
            default: state_d = flash_host_pkg::S_IDLE;
        endcase
    end

    // register all sequencer, register and bus state
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            state_q <= flash_host_pkg::S_IDLE;
            pins_q <= 5'b11111;
            cnt_q <= 8'h00;
            op_q <= 3'h0;
            phase_q <= 2'd0;
            cmd_q <= 8'h00;
            data_q <= 16'h0000;
            addr_q <= '0;
            auto_q <= 1'b0;
            pd_q <= 1'b0;
            array_q <= 1'b1;
            status_q <= 8'h00;
            rdata_q <= 16'h0000;
            dq_q <= 16'h0000;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            state_q <= state_d;
            pins_q <= pins_d;
            cnt_q <= cnt_d;
            op_q <= op_d;
            phase_q <= phase_d;
            cmd_q <= cmd_d;
            data_q <= data_d;
            addr_q <= addr_d;
            auto_q <= auto_d;
            pd_q <= pd_d;
            array_q <= array_d;
            status_q <= status_d;
            rdata_q <= rdata_d;
            dq_q <= dq_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign pins_o = pins_q;
    assign addr_o = addr_q;
    assign dq_o = dq_q;
    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    logic [7:0] since_rp_q;
    // cycles since reset_powerdown_n rose, saturating
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            // reset_powerdown_n stays high through reset: no exit delay owed
            since_rp_q <= 8'hFF;
        end else if (!pins_q.rp_n) begin
            since_rp_q <= 8'h00;
        end else if (since_rp_q != 8'hFF) begin
            since_rp_q <= since_rp_q + 8'h01;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    sequence we_pulse_s;
        pins_q.we_n ##1 !pins_q.we_n [*3] ##1 pins_q.we_n;
    endsequence

    we_under_ce_a: assert property (!pins_q.we_n |-> !pins_q.ce_n)
        else $error("write enable low without chip enable");
    we_drives_bus_a: assert property (!pins_q.we_n |-> !pins_q.dq_oe_n && pins_q.oe_n)
        else $error("write strobe without driven data bus");
    pd_quiet_a: assert property (!pins_q.rp_n |-> pins_q.ce_n && pins_q.we_n)
        else $error("pins active during power-down");
    pd_clears_stat_a: assert property ($fell(pins_q.rp_n) |-> status_q == 8'h00)
        else $error("status copy not cleared at power-down");
    wake_delay_a: assert property (!pins_q.ce_n |-> since_rp_q >= WAKE_C)
        else $error("access before power-down exit delay");
    two_step_a: assert property ((start && new_op == `OP_WR2) |-> ##2
        we_pulse_s ##[1:3] !pins_q.we_n)
        else $error("two-step sequence lacks second write");
    poll_wait_a: assert property ((state_q == flash_host_pkg::S_POLL && !rb_ready)
        |=> state_q == flash_host_pkg::S_POLL && pins_q.ce_n)
        else $error("read-array issued while device busy");
    ff_sets_array_a: assert property ($rose(array_q) && $past(pins_q.rp_n) |->
        $past(state_q) == flash_host_pkg::S_SETUP && dq_q == 16'h00FF)
        else $error("read-array mode without FFH write");
    read_capture_a: assert property ($rose(pins_q.oe_n) |-> rdata_q == $past(dq_sync))
        else $error("read data not captured at strobe end");
endmodule
`default_nettype wire

//--- flash_dev_model.sv
// behavioural model of the parallel flash device behind the host controller
`default_nettype none
module flash_dev_model #(
    parameter int RST_CYC = 12
) (
    input wire logic ref_clk_i,
    input wire flash_host_pkg::pin_ctl_t pins_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] dq_i,
    input wire logic vpp_ok_i,
    input wire logic [15:0] busy_cyc_i,
    output logic [15:0] dq_o,
    output logic ready_busy_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [16];
    logic [15:0] cnt_q = 16'h0000;
    logic [15:0] last_q = 16'h0000;
    logic [6:0] err_q = 7'h00;
    logic [1:0] setup_q = 2'h0;
    logic array_q = 1'b1;
    logic we_q = 1'b1;
    logic [7:0] stat;
    assign stat = {cnt_q == 16'h0000, err_q};
    // always driven, low only while busy
    assign ready_busy_n_o = (cnt_q == 16'h0000);
    // drive while read-enabled, else a pattern that changes every cycle
    assign dq_o = (!pins_i.ce_n && !pins_i.oe_n && pins_i.rp_n) ?
        (array_q ? mem[addr_i] : {8'h00, stat}) : ~last_q;
    // command decode and internal job timing
    always @(posedge ref_clk_i) begin
        last_q <= dq_o;
        we_q <= pins_i.we_n;
        if (!pins_i.rp_n) begin
            err_q <= 7'h00;
            array_q <= 1'b1;
            setup_q <= 2'h0;
            if (cnt_q != 16'h0000) begin
                cnt_q <= (cnt_q > RST_CYC) ? 16'(RST_CYC) : cnt_q - 16'h0001;
            end
        end else begin
            if (cnt_q != 16'h0000) begin
                cnt_q <= cnt_q - 16'h0001;
            end
            // latch on strobe with chip enabled
            if (!we_q && pins_i.we_n && !pins_i.ce_n) begin
                if (setup_q != 2'h0) begin
                    cnt_q <= busy_cyc_i;
                    setup_q <= 2'h0;
                    if (setup_q == 2'h1 && vpp_ok_i) begin
                        mem[addr_i] <= dq_i;
                    end
                    if (!vpp_ok_i) begin
                        err_q <= err_q | ((setup_q == 2'h1) ? 7'h18 : 7'h28);
                    end
                end else begin
                    array_q <= (dq_i[7:0] == 8'hFF);
                    setup_q <= (dq_i[7:0] == 8'h40 || dq_i[7:0] == 8'h10) ? 2'h1 :
                        (dq_i[7:0] == 8'h20) ? 2'h2 : 2'h0;
                    if (dq_i[7:0] == 8'h50) begin
                        err_q <= 7'h00;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- flash_ready_busy_and_power_state_tb_top.sv
// self-checking bench for the flash host controller
`include "flash_host_cfg.svh"
`default_nettype none
module flash_ready_busy_and_power_state_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    flash_host_pkg::pin_ctl_t pins;
    logic [17:0] addr;
    logic [15:0] host_dq;
    logic [15:0] dev_dq;
    logic [15:0] dq_w;
    logic rb_n;
    logic vpp_ok = 1'b1;
    logic [15:0] busy_cyc = 16'h0028;
    int n_fail = 0;
    int n_tests = 0;
    logic [31:0] q;
    logic saw_busy;
    logic [7:0] bad_a [3] = '{8'h18, `STAT_OFS, `CTRL_OFS};
    logic [31:0] bad_d [3] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0006};
    // clock and resolved data bus
    always #10 ref_clk = ~ref_clk;
    assign dq_w = pins.dq_oe_n ? dev_dq : host_dq;
    flash_host dut_u (.ref_clk_i(ref_clk), .reset_i(reset), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .pins_o(pins),
        .addr_o(addr), .dq_o(host_dq), .dq_i(dq_w), .ready_busy_n_i(rb_n));
    flash_dev_model dev_u (.ref_clk_i(ref_clk), .pins_i(pins), .addr_i(addr[3:0]),
        .dq_i(dq_w), .vpp_ok_i(vpp_ok), .busy_cyc_i(busy_cyc), .dq_o(dev_dq),
        .ready_busy_n_o(rb_n));
    // verdict and end of run
    task automatic complete_run();
        if (n_fail == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one apb transfer, waiting for pready without a bound
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        input logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        q = prdata;
        chk("bus_error", {31'h0, pslverr}, {31'h0, err});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    // poll status until the masked busy bits clear
    task automatic wait_ready(input logic [1:0] mask);
        saw_busy = 1'b0;
        do begin
            apb(1'b0, `STAT_OFS, 32'h0, 1'b0);
            saw_busy |= q[`STAT_FLASH_BUSY_BIT];
        end while ((q[1:0] & mask) != 2'b00);
    endtask
    task automatic run(input logic [31:0] ctl, input logic [1:0] mask);
        apb(1'b1, `CTRL_OFS, ctl, 1'b0);
        wait_ready(mask);
    endtask
    task automatic stat_is(input logic [7:0] x);
        run({29'h0, `OP_RD}, 2'b11);
        apb(1'b0, `STAT_OFS, 32'h0, 1'b0);
        chk("status_byte", {24'h0, q[23:16]}, {24'h0, x});
    endtask
    task automatic step(input logic v, input logic [7:0] c, input logic [2:0] o,
        input logic [7:0] x);
        vpp_ok <= v;
        apb(1'b1, `CMD_OFS, {24'h0, c}, 1'b0);
        apb(1'b1, `DATA_OFS, 32'h0000_00D0, 1'b0);
        run({29'h0, o}, 2'b11);
        stat_is(x);
    endtask
    // two-step write with automatic read-array, then read back
    task automatic write_verify(input logic [17:0] a, input logic [15:0] d);
        apb(1'b1, `ADDR_OFS, {14'h0, a}, 1'b0);
        apb(1'b1, `CMD_OFS, 32'h0000_0040, 1'b0);
        apb(1'b1, `DATA_OFS, {16'h0, d}, 1'b0);
        run({23'h0, 1'b1, 5'h0, `OP_WR2}, 2'b11);
        chk("saw_busy", {31'h0, saw_busy}, 32'h0000_0001);
        run({29'h0, `OP_RD}, 2'b11);
        apb(1'b0, `RDATA_OFS, 32'h0, 1'b0);
        chk("array_word", q, {16'h0, d});
    endtask
    // watchdog against a hung sequence
    initial begin
        #1000000;
        n_fail++;
        complete_run();
    end
    // main sequence
    initial begin
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, bad_a[i], bad_d[i], 1'b1);
        end
        write_verify(18'h00001, 16'hA55A);
        step(1'b0, 8'h40, `OP_WR2, 8'h98);
        step(1'b0, 8'h20, `OP_WR2, 8'hB8);
        vpp_ok <= 1'b1;
        busy_cyc <= 16'h012C;
        apb(1'b1, `ADDR_OFS, 32'h0000_0002, 1'b0);
        apb(1'b1, `CMD_OFS, 32'h0000_0040, 1'b0);
        run({29'h0, `OP_WR2}, 2'b01);
        run({29'h0, `OP_PD_ON}, 2'b01);
        chk("busy_in_reset", {31'h0, q[`STAT_FLASH_BUSY_BIT]}, 32'h0000_0001);
        repeat (30) @(posedge ref_clk);
        apb(1'b0, `STAT_OFS, 32'h0, 1'b0);
        chk("powered_down", q, 32'h0000_0004);
        apb(1'b1, `CTRL_OFS, {29'h0, `OP_WR1}, 1'b1);
        run({29'h0, `OP_PD_OFF}, 2'b01);
        chk("wake_mode", {28'h0, q[3:0]}, 32'h0000_0008);
        step(1'b1, 8'h70, `OP_WR1, 8'h80);
        busy_cyc <= 16'h0028;
        write_verify(18'h00002, 16'hBEEF);
        step(1'b0, 8'h40, `OP_WR2, 8'h98);
        step(1'b1, 8'h50, `OP_WR1, 8'h80);
        complete_run();
    end
endmodule
`default_nettype wire
